/* File: design/pmic_regs_pkg.sv */
package pmic_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAULT_SUMMARY  = 8'h00;
  localparam logic [7:0] ADDR_POWER_GOOD     = 8'h01;
  localparam logic [7:0] ADDR_SHORT_CIRCUIT  = 8'h02;
  localparam logic [7:0] ADDR_OVER_VOLTAGE   = 8'h03;
  localparam logic [7:0] ADDR_OVER_CURRENT   = 8'h04;
  localparam logic [7:0] ADDR_ENABLE_MAIN    = 8'h05;
  localparam logic [7:0] ADDR_ENABLE_OVERRIDE = 8'h06;
  localparam logic [7:0] ADDR_DELAY_CH1_CH2  = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_HARD_SHORT     = 7;
  localparam int BIT_RESET_CHECK    = 6;
  localparam int BIT_THERMAL        = 3;
  localparam int BIT_DRIVER_UV      = 2;
  localparam int BIT_OV_SUMMARY     = 1;
  localparam int BIT_SC_SUMMARY     = 0;
  localparam int BIT_PIN_STATE      = 7;
  localparam int POS_GATE_ENABLE    = 3;
  localparam int POS_DELAY_CH2      = 3;
  localparam int POS_DELAY_CH1      = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_FAULT_SUMMARY = 8'h00;
  localparam logic [7:0] RESET_POWER_GOOD    = 8'h80;
  localparam logic [7:0] RESET_STATUS        = 8'h00;
  localparam logic [7:0] RESET_ENABLE_MAIN   = 8'hE5;
  localparam logic [7:0] RESET_ENABLE_OVR    = 8'h00;
  localparam logic [7:0] RESET_DELAY         = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ           = 100;
  localparam int TICK_US             = 1050;
  localparam int TICK_CYCLES_DEFAULT = TICK_US * CLOCK_MHZ;
  localparam int LATCH_STEP_DEFAULT  = 100;
  // Start-up delay per code, in microseconds, and the last code's delay in time-base ticks
  localparam int DELAY_US [8] = '{0, 2100, 3150, 5250, 6300, 8400, 16800, 33600};
  localparam int LAST_TICK = DELAY_US[7] / TICK_US;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} seq_state_t;

endpackage

/* File: design/pmic_fault_enable_seq_regs.sv */
// How it works
// RULE_01: Fault bits 7,6,3,2 report latched faults
// RULE_02: Bit 1 is OR of over-voltage flags
// RULE_03: Bit 0 is OR of short flags
// RULE_04: Fault bits zero when absent, reset zero
// RULE_05: Bit 7 mirrors power-good pin, resets one
// RULE_06: Bits 5..0 show per-output good, reset zero
// RULE_07: Good bits masked during soft-start ramp
// RULE_08: Pin-state bit reads one when enable low
// RULE_09: Short flags switch1 and channels, never masked
// RULE_10: Over-voltage flags channels 4..1, never masked
// RULE_11: Three sticky over-current flags, reset zero
// RULE_12: Writing one clears an over-current flag
// RULE_13: Flag sets after latch timer expires
// RULE_14: Override bit masks over-current flag
// RULE_15: Enable register one bit per output
// RULE_16: Sequencer starts enabled outputs, then direct control
// RULE_17: Gate driver enables in bits 5..3
// RULE_18: Override bits choose shutdown or stay on
// RULE_19: Delay code selects eight start-up delays
// RULE_20: Channel 2 code bits 5..3, channel 1 2..0
// RULE_21: Host sets zero code if not sequenced
// RULE_22: Delays counted from common start on time base
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module pmic_fault_enable_seq_regs
  import pmic_regs_pkg::*;
#(
  parameter int TICK_CYCLES       = TICK_CYCLES_DEFAULT,
  parameter int LATCH_STEP_CYCLES = LATCH_STEP_DEFAULT
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Pins and analog monitors (asynchronous)
  input  wire logic       global_enable,
  input  wire logic       power_good_output,
  input  wire logic       hard_short_flag,
  input  wire logic       reset_check_error,
  input  wire logic       thermal_shutdown_flag,
  input  wire logic       driver_supply_undervoltage,
  input  wire logic [4:0] channel_short_flags,
  input  wire logic [3:0] channel_overvoltage_flags,
  input  wire logic [5:0] channel_good_raw,
  input  wire logic [5:0] soft_start_active,
  input  wire logic [2:0] current_sense_overcurrent,
  // Latch timer settings of current-sense paths 3..1
  input  wire logic [5:0] overcurrent_latch_timer3,
  input  wire logic [5:0] overcurrent_latch_timer2,
  input  wire logic [5:0] overcurrent_latch_timer1,
  // Controls to the power stages
  output logic      [7:0] output_enable_bits,
  output logic      [2:0] switch_gate_driver,
  output logic            sequence_done
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = 30;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] filt;
  logic [SYNC_W-1:0] agree;

  assign raw_in = {global_enable, power_good_output, hard_short_flag, reset_check_error,
                   thermal_shutdown_flag, driver_supply_undervoltage, channel_short_flags,
                   channel_overvoltage_flags, channel_good_raw, soft_start_active,
                   current_sense_overcurrent};
  assign agree = ~(sync2 ^ sync3);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt  <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= (filt & ~agree) | (sync3 & agree);
    end
  end

  logic       en_pin;
  logic       pg_pin;
  logic [3:0] fault_in;
  logic [4:0] short_in;
  logic [3:0] ov_in;
  logic [5:0] good_in;
  logic [5:0] ramp_in;
  logic [2:0] oc_in;

  assign en_pin   = filt[29];
  assign pg_pin   = filt[28];
  assign fault_in = filt[27:24];
  assign short_in = filt[23:19];
  assign ov_in    = filt[18:15];
  assign good_in  = filt[14:9];
  assign ramp_in  = filt[8:3];
  assign oc_in    = filt[2:0];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_fault;
  logic wr_oc;
  logic wr_en_main;
  logic wr_en_ovr;
  logic wr_delay;

  assign wr_fault   = reg_write && (reg_addr == ADDR_FAULT_SUMMARY);
  assign wr_oc      = reg_write && (reg_addr == ADDR_OVER_CURRENT);
  assign wr_en_main = reg_write && (reg_addr == ADDR_ENABLE_MAIN);
  assign wr_en_ovr  = reg_write && (reg_addr == ADDR_ENABLE_OVERRIDE);
  assign wr_delay   = reg_write && (reg_addr == ADDR_DELAY_CH1_CH2);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] enable_main;
  logic [7:0] enable_ovr;
  logic [7:0] delay_codes;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      enable_main <= RESET_ENABLE_MAIN;
      enable_ovr  <= RESET_ENABLE_OVR;
      delay_codes <= RESET_DELAY;
    end else begin
      if (wr_en_main) begin
        enable_main <= reg_wdata;                        // [RULE_15]
      end
      if (wr_en_ovr) begin
        enable_ovr <= {2'b00, reg_wdata[5:0]};           // [RULE_17] [RULE_18]
      end
      if (wr_delay) begin
        delay_codes <= {2'b00, reg_wdata[5:0]};          // [RULE_20]
      end
    end
  end

  logic [2:0] override_bits;
  logic [2:0] gate_enable;
  logic [2:0] code_ch1;
  logic [2:0] code_ch2;

  assign override_bits = enable_ovr[2:0];
  assign gate_enable   = enable_ovr[POS_GATE_ENABLE +: 3];
  assign code_ch1      = delay_codes[POS_DELAY_CH1 +: 3];
  assign code_ch2      = delay_codes[POS_DELAY_CH2 +: 3];

  // ----------------------------------------------------------------
  // Fault summary
  // ----------------------------------------------------------------
  logic [3:0] fault_sticky;
  logic [3:0] fault_clear;

  assign fault_clear = wr_fault ? {reg_wdata[BIT_HARD_SHORT], reg_wdata[BIT_RESET_CHECK],
                                   reg_wdata[BIT_THERMAL], reg_wdata[BIT_DRIVER_UV]} : 4'h0;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      fault_sticky <= RESET_FAULT_SUMMARY[3:0];          // [RULE_04]
    end else begin
      fault_sticky <= (fault_sticky & ~fault_clear) | fault_in; // [RULE_01]
    end
  end

  logic [7:0] fault_word;
  always_comb begin
    fault_word                 = 8'h00;
    fault_word[BIT_HARD_SHORT] = fault_sticky[3];        // [RULE_01]
    fault_word[BIT_RESET_CHECK] = fault_sticky[2];
    fault_word[BIT_THERMAL]    = fault_sticky[1];
    fault_word[BIT_DRIVER_UV]  = fault_sticky[0];
    fault_word[BIT_OV_SUMMARY] = |ov_in;                 // [RULE_02]
    fault_word[BIT_SC_SUMMARY] = |short_in;              // [RULE_03]
  end

  // ----------------------------------------------------------------
  // Power-good status
  // ----------------------------------------------------------------
  logic [7:0] power_good;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      power_good <= RESET_POWER_GOOD;                    // [RULE_05] [RULE_06]
    end else begin
      power_good[BIT_PIN_STATE] <= pg_pin || !en_pin;    // [RULE_05] [RULE_08]
      power_good[6]             <= 1'b0;
      power_good[5:0]           <= good_in & ~ramp_in;   // [RULE_06] [RULE_07]
    end
  end

  // ----------------------------------------------------------------
  // Over-current latch timers and sticky flags
  // ----------------------------------------------------------------
  logic [31:0] step_cnt;
  logic        step;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      step_cnt <= '0;
    end else if (step) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + 32'd1;
    end
  end
  assign step = (step_cnt == 32'(LATCH_STEP_CYCLES - 1));

  logic [5:0] latch_limit [3];
  logic [2:0] oc_flags;
  logic [2:0] oc_expired;

  assign latch_limit[0] = overcurrent_latch_timer1;
  assign latch_limit[1] = overcurrent_latch_timer2;
  assign latch_limit[2] = overcurrent_latch_timer3;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_path
      logic [5:0] lat_cnt;
      always_ff @(posedge clock) begin
        if (!nrst) begin
          lat_cnt <= 6'h00;
        end else if (!oc_in[p]) begin
          lat_cnt <= 6'h00;
        end else if (step && (lat_cnt != 6'h3F)) begin
          lat_cnt <= lat_cnt + 6'h01;
        end
      end
      assign oc_expired[p] = oc_in[p] && (lat_cnt >= latch_limit[p]); // [RULE_13]

      always_ff @(posedge clock) begin
        if (!nrst) begin
          oc_flags[p] <= 1'b0;                           // [RULE_11]
        end else if (oc_expired[p] && !override_bits[p]) begin
          oc_flags[p] <= 1'b1;                           // [RULE_13] [RULE_14]
        end else if (override_bits[p]) begin
          oc_flags[p] <= 1'b0;                           // [RULE_14]
        end else if (wr_oc && reg_wdata[p]) begin
          oc_flags[p] <= 1'b0;                           // [RULE_12]
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  seq_state_t  seq_state;
  logic        en_prev;
  logic [31:0] tick_cnt;
  logic [5:0]  elapsed;
  logic        tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  function automatic logic [5:0] delay_ticks(input logic [2:0] code);
    logic [5:0] t;
    t = 6'h00;
    for (int i = 0; i < 8; i++) begin
      if (code == 3'(i)) begin
        t = 6'(DELAY_US[i] / TICK_US);                   // [RULE_19]
      end
    end
    return t;
  endfunction

  always_ff @(posedge clock) begin
    if (!nrst) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= en_pin;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      seq_state <= SEQ_IDLE;
      tick_cnt  <= '0;
      elapsed   <= 6'h00;
    end else begin
      case (seq_state)
        SEQ_IDLE: begin
          tick_cnt <= '0;
          elapsed  <= 6'h00;
          if (en_pin && !en_prev) begin
            seq_state <= SEQ_RUN;                        // [RULE_22]
          end
        end
        SEQ_RUN: begin
          if (!en_pin) begin
            seq_state <= SEQ_IDLE;
          end else if (tick) begin
            tick_cnt <= '0;
            elapsed  <= elapsed + 6'h01;                 // [RULE_22]
            if (elapsed == 6'(LAST_TICK)) begin
              seq_state <= SEQ_DONE;
            end
          end else begin
            tick_cnt <= tick_cnt + 32'd1;
          end
        end
        SEQ_DONE: begin
          if (!en_pin) begin
            seq_state <= SEQ_IDLE;
          end
        end
        default: begin
          seq_state <= SEQ_IDLE;
        end
      endcase
    end
  end

  logic [7:0] started;
  always_comb begin
    started    = 8'hFC;                                  // Outputs without a code here start at once
    started[0] = (elapsed >= delay_ticks(code_ch1));     // [RULE_19] [RULE_22]
    started[1] = (elapsed >= delay_ticks(code_ch2));
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      output_enable_bits <= 8'h00;
      sequence_done      <= 1'b0;
    end else begin
      sequence_done <= (seq_state == SEQ_DONE);
      case (seq_state)
        SEQ_RUN:  output_enable_bits <= enable_main & started; // [RULE_16]
        SEQ_DONE: output_enable_bits <= enable_main;           // [RULE_16]
        default:  output_enable_bits <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External switch gate drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      switch_gate_driver <= 3'b000;
    end else begin
      switch_gate_driver <= gate_enable & ~(oc_expired & ~override_bits); // [RULE_17] [RULE_18]
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_FAULT_SUMMARY:   reg_rdata <= fault_word;
        ADDR_POWER_GOOD:      reg_rdata <= power_good;
        ADDR_SHORT_CIRCUIT:   reg_rdata <= {3'b000, short_in};        // [RULE_09]
        ADDR_OVER_VOLTAGE:    reg_rdata <= {4'h0, ov_in};             // [RULE_10]
        ADDR_OVER_CURRENT:    reg_rdata <= {5'b00000, oc_flags};      // [RULE_11]
        ADDR_ENABLE_MAIN:     reg_rdata <= enable_main;
        ADDR_ENABLE_OVERRIDE: reg_rdata <= enable_ovr;
        ADDR_DELAY_CH1_CH2:   reg_rdata <= delay_codes;
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: test/pmic_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module pmic_regs_chk
  import pmic_regs_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // Pins and controls
  input wire logic       global_enable,
  input wire logic [7:0] output_enable_bits,
  input wire logic [2:0] switch_gate_driver,
  input wire logic       sequence_done
);
  logic [7:0] last_enable;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Last value written to the main enable register
  always_ff @(posedge clock) begin
    if (reg_write && reg_addr == ADDR_ENABLE_MAIN) begin
      last_enable <= reg_wdata;
    end
  end

  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  unmapped_rd_a: assert property ($past(reg_read) && $past(reg_addr) > 8'h07 |-> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  fault_gap_a: assert property (reg_read && reg_addr == ADDR_FAULT_SUMMARY |=> reg_rdata[5:4] == 2'b00)
    else $error("unused fault bits set");
  pin_forced_a: assert property (!global_enable [*7] ##0 reg_read && reg_addr == ADDR_POWER_GOOD |=> reg_rdata[7])
    else $error("pin state bit low while enable low");
  short_width_a: assert property (reg_read && reg_addr == ADDR_SHORT_CIRCUIT |=> reg_rdata[7:5] == 3'b000)
    else $error("short status upper bits set");
  ov_width_a: assert property (reg_read && reg_addr == ADDR_OVER_VOLTAGE |=> reg_rdata[7:4] == 4'h0)
    else $error("over-voltage status upper bits set");
  oc_width_a: assert property (reg_read && reg_addr == ADDR_OVER_CURRENT |=> reg_rdata[7:3] == 5'h00)
    else $error("over-current status upper bits set");
  delay_width_a: assert property (reg_read && reg_addr == ADDR_DELAY_CH1_CH2 |=> reg_rdata[7:6] == 2'b00)
    else $error("delay register upper bits set");
  reset_out_a: assert property ($rose(nrst) |-> output_enable_bits == 8'h00 && switch_gate_driver == 3'b000 && !sequence_done)
    else $error("outputs active out of reset");
  enable_off_a: assert property (!global_enable [*8] |-> output_enable_bits == 8'h00 && !sequence_done)
    else $error("outputs on while enable pin low");
  direct_ctl_a: assert property (sequence_done && reg_write && reg_addr == ADDR_ENABLE_MAIN
    |-> ##[2:3] (output_enable_bits == last_enable || !sequence_done))
    else $error("outputs do not follow enable register after sequence");
endmodule
`default_nettype wire

/* File: test/pmic_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pmic_host_model (
  // Clock
  input  wire logic       clock,
  // Register port
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_write,
  output var  logic       reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // One-cycle write; a one written to a sticky flag clears it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: test/pmic_fault_enable_seq_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pmic_fault_enable_seq_regs_tb_top
  import pmic_regs_pkg::*;
;
  localparam int TICK = 10;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] want;
  } row_t;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic       global_enable = 1'b0;
  logic       pg_pin = 1'b0;
  logic [3:0] faults = 4'h0;
  logic [4:0] shorts = 5'h00;
  logic [3:0] overs = 4'h0;
  logic [5:0] good_raw = 6'h00;
  logic [5:0] ramping = 6'h00;
  logic [2:0] oc = 3'h0;
  logic [5:0] lat = 6'h03;
  logic [7:0] out_en;
  logic [2:0] gates;
  logic       done;
  logic [7:0] rdv;
  int         errors = 0;
  int         num_checks = 0;
  int         n;
  row_t       rows [9] = '{'{8'h05, 8'h5A, 8'h5A}, '{8'h06, 8'hFF, 8'h3F}, '{8'h07, 8'hFF, 8'h3F},
                          '{8'h00, 8'hFF, 8'h00}, '{8'h01, 8'h00, 8'h80}, '{8'h02, 8'hFF, 8'h00},
                          '{8'h03, 8'hFF, 8'h00}, '{8'h04, 8'hFF, 8'h00}, '{8'h1F, 8'hFF, 8'h00}};
  logic [7:0] rst_vals [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'hE5, 8'h00, 8'h00};

  always #5 clock = ~clock;

  pmic_fault_enable_seq_regs #(
    .TICK_CYCLES       (TICK),
    .LATCH_STEP_CYCLES (2)
  ) uut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .global_enable(global_enable), .power_good_output(pg_pin), .hard_short_flag(faults[3]),
    .reset_check_error(faults[2]), .thermal_shutdown_flag(faults[1]),
    .driver_supply_undervoltage(faults[0]), .channel_short_flags(shorts),
    .channel_overvoltage_flags(overs), .channel_good_raw(good_raw), .soft_start_active(ramping),
    .current_sense_overcurrent(oc), .overcurrent_latch_timer3(lat),
    .overcurrent_latch_timer2(lat), .overcurrent_latch_timer1(lat),
    .output_enable_bits(out_en), .switch_gate_driver(gates), .sequence_done(done)
  );

  pmic_host_model host (
    .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
    host.rd(a, rdv);
    check(16'(rdv), 16'(want));
  endtask

  task automatic settle;
    repeat (8) @(posedge clock);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      host.wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].want);
    end
    // Sticky faults and live summaries
    faults <= 4'hF;
    overs <= 4'h4;
    shorts <= 5'h10;
    settle();
    faults <= 4'h0;
    settle();
    rd_chk(8'h00, 8'hCF);
    rd_chk(8'h03, 8'h04);
    rd_chk(8'h02, 8'h10);
    host.wr(8'h00, 8'h44);
    rd_chk(8'h00, 8'h8B);
    overs <= 4'h0;
    shorts <= 5'h00;
    host.wr(8'h00, 8'h88);
    settle();
    rd_chk(8'h00, 8'h00);
    // Over-current latch, override and clear
    host.wr(8'h06, 8'h38);
    settle();
    check(16'(gates), 16'h0007);
    oc <= 3'b001;
    repeat (3) @(posedge clock);
    oc <= 3'b000;
    settle();
    rd_chk(8'h04, 8'h00);
    oc <= 3'b111;
    repeat (30) @(posedge clock);
    rd_chk(8'h04, 8'h07);
    check(16'(gates), 16'h0000);
    host.wr(8'h06, 8'h3C);
    settle();
    rd_chk(8'h04, 8'h03);
    check(16'(gates), 16'h0004);
    oc <= 3'b000;
    settle();
    host.wr(8'h04, 8'h01);
    rd_chk(8'h04, 8'h02);
    host.wr(8'h04, 8'h00);
    rd_chk(8'h04, 8'h02);
    // Every delay code, measured against the undelayed channel
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h05, 8'h03);
      host.wr(8'h07, 8'(c));
      global_enable <= 1'b1;
      n = 0;
      while (out_en[1] !== 1'b1 && n < 100) begin
        @(posedge clock);
        n++;
      end
      n = 0;
      while (out_en[0] !== 1'b1 && n < 400) begin
        @(posedge clock);
        n++;
      end
      check(16'(n), 16'(DELAY_US[c] / TICK_US * TICK));
      if (c == 7) begin
        n = 0;
        while (done !== 1'b1 && n < 100) begin
          @(posedge clock);
          n++;
        end
        check(16'(done), 16'h0001);
        host.wr(8'h05, 8'h81);
        repeat (3) @(posedge clock);
        check(16'(out_en), 16'h0081);
        good_raw <= 6'h3F;
        ramping <= 6'h03;
        settle();
        rd_chk(8'h01, 8'h3C);
        pg_pin <= 1'b1;
        ramping <= 6'h00;
        settle();
        rd_chk(8'h01, 8'hBF);
      end
      global_enable <= 1'b0;
      repeat (10) @(posedge clock);
    end
    // Mid-run reset restores every register
    good_raw <= 6'h00;
    nrst <= 1'b0;
    repeat (10) @(posedge clock);
    check(16'({out_en, 5'h00, gates}), 16'h0000);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_chk(8'(a), rst_vals[a]);
    end
    tally_and_finish();
  end
endmodule

bind pmic_fault_enable_seq_regs pmic_regs_chk chk (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .global_enable(global_enable), .output_enable_bits(output_enable_bits),
  .switch_gate_driver(switch_gate_driver), .sequence_done(sequence_done)
);
`default_nettype wire
